// ### core/slpctl_pkg.sv
/*
 Shared constants and types of the sleep and power-gating controller.
 Assumes a 32-bit AXI4-Lite register bus with 8-bit byte addresses.
*/
package slpctl_pkg;

  // ==========================================================
  // Register map: the byte address is four times the register index
  localparam logic [7:0] SC_INDEX = 8'h35;
  localparam logic [7:0] PR_INDEX = 8'h36;
  localparam logic [7:0] ST_INDEX = 8'h37;
  localparam logic [7:0] SC_ADDR = 8'(SC_INDEX * 4);
  localparam logic [7:0] PR_ADDR = 8'(PR_INDEX * 4);
  localparam logic [7:0] ST_ADDR = 8'(ST_INDEX * 4);

  // ==========================================================
  // Field layout and reset values
  localparam int SLEEP_EN_BIT = 5;
  localparam int MODE_SEL_LSB = 3;
  localparam logic [7:0] SC_WMASK = 8'h7b;
  localparam logic [7:0] SC_RESET = 8'h00;
  localparam logic [7:0] PR_WMASK = 8'h0f;
  localparam logic [7:0] PR_RESET = 8'h00;
  localparam int PR_TIMER1_BIT = 3;
  localparam int PR_TIMER0_BIT = 2;
  localparam int PR_SERIAL_BIT = 1;
  localparam int PR_CONV_BIT = 0;

  // ==========================================================
  // Timing counts, in system clock cycles
  localparam int WAKE_HOLD_CYC = 4;
  localparam int STANDBY_WAKE_CYC = 6;
  localparam int OSC_STARTUP_CYC = 16384;
  localparam int WAKE_CNT_W = 16;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_SLEEP = 3'b010,
    ST_WAKE = 3'b100
  } slpctl_state_t;

  typedef enum logic [1:0] {
    MODE_IDLE = 2'h0,
    MODE_ADC_NR = 2'h1,
    MODE_PDOWN = 2'h2,
    MODE_STANDBY = 2'h3
  } slpctl_mode_t;

  typedef struct packed {
    logic ext_edge;
    logic ext0_level;
    logic ext1_level;
    logic pin_change;
    logic spm_ready;
    logic adc_done;
    logic wdt_irq;
    logic serial_irq;
    logic other_io;
  } slpctl_wake_t;

  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic pll_fast_clock;
    logic osc;
  } slpctl_clk_t;

  typedef struct packed {
    logic comparator;
    logic timer1;
    logic timer0;
    logic serial_iface;
    logic converter;
  } slpctl_periph_t;

endpackage

// ### core/slpctl_top.sv
/*
 Sleep mode and power-gating controller: sleep control and power
 reduction registers on AXI4-Lite, clock domain gating, wake-up
 qualification and wake-up delay.
 Assumes the CPU pulses i_sleep_exec for one cycle when it executes the
 sleep instruction, and wake sources are interrupt requests already
 enabled and synchronous to I_CLK_SYS. Chip resets arrive on I_RESET.
*/
// Local design decision: register access over AXI4-Lite.
// Summary of operation
// - Sleep is entered only when sleep enable is set at the sleep instruction.
// - Mode 00 Idle: CPU and flash clocks stop, other clocks keep running.
// - Idle wakes on any enabled interrupt source.
// - Entering Idle or ADC noise reduction with ADC enabled starts one conversion.
// - Mode 01 ADC noise reduction: I/O, CPU, flash clocks stop; ADC, oscillator run.
// - Noise reduction wakes on ADC, SPM ready, watchdog, level irq, pin change.
// - Mode 10 Power-down: oscillator and every generated clock stop.
// - Power-down wakes on watchdog interrupt, level irq, pin change, or reset.
// - In deeper modes external interrupts wake only as levels, never edges.
// - Mode 11 with crystal: Standby keeps oscillator, wakes in six cycles.
// - Wake by interrupt holds CPU four cycles beyond start-up (Standby: six cycles in all), then resumes.
// - Register file and SRAM keep their contents across sleep.
// - A reset during sleep leaves sleep and restarts at the reset vector.
// - Power reduction bit stops peripheral clock and blocks its register access.
// - Clearing the bit restarts the clock from the frozen state.
// - Bit 3 timer1, 2 timer0, 1 serial, 0 ADC; bits 7..4 read zero.
// - ADC off before its gate; that gate also stops comparator clock.
// - With I/O and ADC clocks stopped, non-wake input buffers are disabled.
// - Power-down and Standby disable comparator unless internal reference used.
// - Sleep control resets to zero; bits 7 and 2 read zero.
`timescale 1ns/1ns
module slpctl_top #(
  parameter int STARTUP_CYC = slpctl_pkg::OSC_STARTUP_CYC
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RESET,
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_SLEEP_EXEC,
  input wire slpctl_pkg::slpctl_wake_t I_WAKE,
  input wire logic I_CRYSTAL_SEL,
  input wire logic I_ADC_ENABLED,
  input wire logic I_COMP_INT_REF,
  output slpctl_pkg::slpctl_clk_t O_CLK_EN,
  output slpctl_pkg::slpctl_periph_t O_PERIPH_CLK_EN,
  output slpctl_pkg::slpctl_periph_t O_PERIPH_IO_BLOCK,
  output logic O_ADC_START,
  output logic O_IRQ_RESUME,
  output logic O_INPUT_BUF_EN,
  output logic O_COMP_DISABLE,
  output logic [7:0] O_SLEEP_CTRL
);
  import slpctl_pkg::*;

  localparam logic [WAKE_CNT_W-1:0] HOLD_LOAD = WAKE_CNT_W'(WAKE_HOLD_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] SBY_LOAD = WAKE_CNT_W'(STANDBY_WAKE_CYC - 1);
  localparam logic [WAKE_CNT_W-1:0] PD_LOAD = WAKE_CNT_W'(STARTUP_CYC + WAKE_HOLD_CYC - 1);

  // ==========================================================
  // Register bus
  logic aw_have_r, w_have_r, bvalid_r, rvalid_r;
  logic [7:0] aw_addr_r, wdata_r;
  logic wstrb0_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic [7:0] sleep_control_r, power_reduction_r;

  wire aw_take = I_AWVALID && O_AWREADY;
  wire w_take = I_WVALID && O_WREADY;
  wire wr_fire = aw_have_r && w_have_r && !bvalid_r;
  wire wr_sc = wr_fire && wstrb0_r && aw_addr_r == SC_ADDR;
  wire wr_pr = wr_fire && wstrb0_r && aw_addr_r == PR_ADDR;
  wire wr_hit = aw_addr_r == SC_ADDR || aw_addr_r == PR_ADDR || aw_addr_r == ST_ADDR;
  wire ar_take = I_ARVALID && O_ARREADY;
  wire rd_hit = I_ARADDR == SC_ADDR || I_ARADDR == PR_ADDR || I_ARADDR == ST_ADDR;

  assign O_AWREADY = !aw_have_r && !bvalid_r;
  assign O_WREADY = !w_have_r && !bvalid_r;
  assign O_ARREADY = !rvalid_r;
  assign O_BVALID = bvalid_r;
  assign O_BRESP = bresp_r;
  assign O_RVALID = rvalid_r;
  assign O_RDATA = rdata_r;
  assign O_RRESP = rresp_r;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= 8'h00;
      wdata_r <= 8'h00;
      wstrb0_r <= 1'b0;
    end else begin
      if (aw_take) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= I_AWADDR;
      end else if (wr_fire) begin
        aw_have_r <= 1'b0;
      end
      if (w_take) begin
        w_have_r <= 1'b1;
        wdata_r <= I_WDATA[7:0];
        wstrb0_r <= I_WSTRB[0];
      end else if (wr_fire) begin
        w_have_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_BREADY) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      sleep_control_r <= SC_RESET;
      power_reduction_r <= PR_RESET;
    end else begin
      if (wr_sc) begin
        sleep_control_r <= wdata_r & SC_WMASK;
      end
      if (wr_pr) begin
        power_reduction_r <= wdata_r & PR_WMASK;
      end
    end
  end

  // ==========================================================
  // Sleep sequencer
  slpctl_state_t state_r, state_nxt;
  slpctl_mode_t mode_r, mode_nxt;
  logic [WAKE_CNT_W-1:0] cnt_r, cnt_nxt;
  logic adc_start_r, resume_r;
  slpctl_clk_t clk_r, clk_nxt;

  wire sleep_enable = sleep_control_r[SLEEP_EN_BIT];
  wire [1:0] sleep_mode_select = sleep_control_r[MODE_SEL_LSB+1:MODE_SEL_LSB];
  wire enter = state_r == ST_RUN && I_SLEEP_EXEC && sleep_enable;
  wire [1:0] mode_eff = (sleep_mode_select == MODE_STANDBY && !I_CRYSTAL_SEL) ?
    MODE_PDOWN : sleep_mode_select;
  wire is_deep = mode_r == MODE_PDOWN || mode_r == MODE_STANDBY;
  wire level_wake = I_WAKE.ext0_level || I_WAKE.ext1_level || I_WAKE.pin_change;
  wire idle_wake = |I_WAKE;
  wire nr_wake = level_wake || I_WAKE.adc_done || I_WAKE.spm_ready || I_WAKE.wdt_irq;
  wire pd_wake = level_wake || I_WAKE.wdt_irq;
  wire wake_hit = mode_r == MODE_IDLE ? idle_wake :
    mode_r == MODE_ADC_NR ? nr_wake : pd_wake;
  wire [WAKE_CNT_W-1:0] wake_load = mode_r == MODE_PDOWN ? PD_LOAD :
    mode_r == MODE_STANDBY ? SBY_LOAD : HOLD_LOAD;

  always_comb begin
    state_nxt = state_r;
    mode_nxt = mode_r;
    cnt_nxt = cnt_r;
    case (state_r)
      ST_RUN: begin
        if (enter) begin
          state_nxt = ST_SLEEP;
          mode_nxt = slpctl_mode_t'(mode_eff);
        end
      end
      ST_SLEEP: begin
        if (wake_hit) begin
          state_nxt = ST_WAKE;
          cnt_nxt = wake_load;
        end
      end
      ST_WAKE: begin
        if (cnt_r == '0) begin
          state_nxt = ST_RUN;
        end else begin
          cnt_nxt = cnt_r - WAKE_CNT_W'(1);
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_comb begin
    clk_nxt = '1;
    if (state_nxt != ST_RUN) begin
      clk_nxt.cpu = 1'b0;
      clk_nxt.flash = 1'b0;
      case (mode_nxt)
        MODE_IDLE: begin
        end
        MODE_ADC_NR: begin
          clk_nxt.io = 1'b0;
          clk_nxt.pll_fast_clock = 1'b0;
        end
        default: begin
          if (state_nxt == ST_SLEEP) begin
            clk_nxt.io = 1'b0;
            clk_nxt.adc = 1'b0;
            clk_nxt.pll_fast_clock = 1'b0;
            clk_nxt.osc = mode_nxt == MODE_STANDBY;
          end
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      state_r <= ST_RUN;
      mode_r <= MODE_IDLE;
      cnt_r <= '0;
      clk_r <= '1;
      adc_start_r <= 1'b0;
      resume_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      mode_r <= mode_nxt;
      cnt_r <= cnt_nxt;
      clk_r <= clk_nxt;
      adc_start_r <= enter && I_ADC_ENABLED && !mode_eff[1];
      resume_r <= state_r == ST_WAKE && cnt_r == '0;
    end
  end

  // ==========================================================
  // Outputs and status readback
  wire [7:0] pr = power_reduction_r;
  slpctl_periph_t gate;
  assign gate.timer1 = pr[PR_TIMER1_BIT];
  assign gate.timer0 = pr[PR_TIMER0_BIT];
  assign gate.serial_iface = pr[PR_SERIAL_BIT];
  assign gate.converter = pr[PR_CONV_BIT];
  assign gate.comparator = pr[PR_CONV_BIT];

  assign O_PERIPH_CLK_EN = ~gate;
  assign O_PERIPH_IO_BLOCK = gate;
  assign O_CLK_EN = clk_r;
  assign O_ADC_START = adc_start_r;
  assign O_IRQ_RESUME = resume_r;
  assign O_SLEEP_CTRL = sleep_control_r;
  // buffers off when io and adc stop
  assign O_INPUT_BUF_EN = clk_r.io || clk_r.adc;
  assign O_COMP_DISABLE = state_r == ST_SLEEP && is_deep && !I_COMP_INT_REF;

  wire [31:0] status_word = {21'h0, mode_r, clk_r, state_r};
  wire [31:0] rd_mux = I_ARADDR == SC_ADDR ? {24'h000000, sleep_control_r} :
    I_ARADDR == PR_ADDR ? {24'h000000, power_reduction_r} :
    I_ARADDR == ST_ADDR ? status_word : 32'h00000000;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RESET) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_mux;
      rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (I_RREADY) begin
      rvalid_r <= 1'b0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_sleep_wake(slpctl_mode_t m);
    state_r == ST_SLEEP && mode_r == m && wake_hit;
  endsequence

  chk_no_enable_nop: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    state_r == ST_RUN && I_SLEEP_EXEC && !sleep_enable |=> state_r == ST_RUN)
    else $error("sleep entered without enable");
  chk_idle_clocks: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    state_r == ST_RUN && enter && mode_eff == MODE_IDLE |=>
      !O_CLK_EN.cpu && !O_CLK_EN.flash && O_CLK_EN.io && O_CLK_EN.adc && O_CLK_EN.osc)
    else $error("idle clock set wrong");
  chk_pdown_clocks: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    enter && mode_eff == MODE_PDOWN |=> O_CLK_EN == '0)
    else $error("power-down clocks not all off");
  chk_adc_autostart: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    enter && I_ADC_ENABLED && mode_eff == MODE_ADC_NR |=> O_ADC_START ##1 !O_ADC_START)
    else $error("conversion not started once");
  chk_edge_ignored: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    state_r == ST_SLEEP && is_deep && I_WAKE.ext_edge && !I_WAKE.ext0_level &&
      !I_WAKE.ext1_level && !I_WAKE.pin_change && !I_WAKE.wdt_irq |=>
      state_r == ST_SLEEP)
    else $error("edge woke deep sleep");
  chk_standby_six: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    s_sleep_wake(MODE_STANDBY) |=> (state_r == ST_WAKE)[*6] ##1 state_r == ST_RUN)
    else $error("standby wake not six cycles");
  chk_idle_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    s_sleep_wake(MODE_IDLE) |=> (!O_CLK_EN.cpu)[*4] ##1 O_CLK_EN.cpu && O_IRQ_RESUME)
    else $error("wake hold not four cycles");
  chk_gate_blocks: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    wr_pr && wdata_r[PR_CONV_BIT] |=> O_PERIPH_IO_BLOCK.converter &&
      !O_PERIPH_CLK_EN.comparator)
    else $error("converter gate not applied");
  chk_comp_off: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    state_r == ST_SLEEP && mode_r == MODE_PDOWN && !I_COMP_INT_REF |-> O_COMP_DISABLE)
    else $error("comparator left on");
  chk_reserved_zero: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    wr_sc |=> sleep_control_r[7] == 1'b0 && sleep_control_r[2] == 1'b0)
    else $error("reserved bit stored");
  chk_nr_clocks: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    enter && mode_eff == MODE_ADC_NR |=> !O_CLK_EN.cpu && !O_CLK_EN.flash && !O_CLK_EN.io &&
      O_CLK_EN.adc && O_CLK_EN.osc)
    else $error("noise reduction clock set wrong");
  chk_nr_refuse: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    state_r == ST_SLEEP && mode_r == MODE_ADC_NR && !I_WAKE.ext0_level &&
      !I_WAKE.ext1_level && !I_WAKE.pin_change && !I_WAKE.adc_done &&
      !I_WAKE.spm_ready && !I_WAKE.wdt_irq |=> state_r == ST_SLEEP)
    else $error("noise reduction woke on a refused source");
  chk_nr_hold: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    s_sleep_wake(MODE_ADC_NR) |=> (!O_CLK_EN.cpu)[*4] ##1 O_CLK_EN.cpu && O_IRQ_RESUME)
    else $error("noise reduction hold not four cycles");
  chk_deep_no_start: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    enter && mode_eff[1] |=> !O_ADC_START)
    else $error("conversion started in deep sleep");
  chk_no_crystal: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    enter && sleep_mode_select == 2'h3 && !I_CRYSTAL_SEL |=> O_CLK_EN == '0)
    else $error("standby without crystal kept a clock");
  chk_resume_once: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    O_IRQ_RESUME |=> !O_IRQ_RESUME)
    else $error("resume pulse longer than one cycle");
  chk_gate_clear: assert property (@(posedge I_CLK_SYS) disable iff (I_RESET)
    wr_pr && !wdata_r[PR_TIMER1_BIT] |=> O_PERIPH_CLK_EN.timer1)
    else $error("timer gate not released");
  chk_reset_run: assert property (@(posedge I_CLK_SYS)
    I_RESET |=> state_r == ST_RUN && O_CLK_EN == '1 && !O_IRQ_RESUME)
    else $error("reset did not return to run");

endmodule

// ### test/tb.sv
/*
 Self-checking bench of the sleep and power-gating controller.
 Assumes slpctl_pkg and slpctl_top are compiled first; the bench drives every port itself.
*/
`timescale 1ns/1ns
module tb;
  import slpctl_pkg::*;
  // ==========================================================
  // Ports and counters
  // Short start-up so the power-down wake stays quick to simulate
  localparam int STARTUP = 8;
  logic I_CLK_SYS, I_RESET, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic [7:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA;
  logic [3:0] I_WSTRB;
  logic I_SLEEP_EXEC, I_CRYSTAL_SEL, I_ADC_ENABLED, I_COMP_INT_REF;
  slpctl_wake_t I_WAKE;
  logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
  logic [1:0] O_BRESP, O_RRESP;
  logic [31:0] O_RDATA;
  slpctl_clk_t O_CLK_EN;
  slpctl_periph_t O_PERIPH_CLK_EN, O_PERIPH_IO_BLOCK;
  logic O_ADC_START, O_IRQ_RESUME, O_INPUT_BUF_EN, O_COMP_DISABLE;
  logic [7:0] O_SLEEP_CTRL;
  int n_errors = 0;
  int tests_run = 0;

  slpctl_top #(.STARTUP_CYC(STARTUP)) i_slpctl_top (
    .I_CLK_SYS(I_CLK_SYS), .I_RESET(I_RESET), .I_AWADDR(I_AWADDR), .I_AWVALID(I_AWVALID),
    .O_AWREADY(O_AWREADY), .I_WDATA(I_WDATA), .I_WSTRB(I_WSTRB), .I_WVALID(I_WVALID),
    .O_WREADY(O_WREADY), .O_BRESP(O_BRESP), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY),
    .I_ARADDR(I_ARADDR), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY), .O_RDATA(O_RDATA),
    .O_RRESP(O_RRESP), .O_RVALID(O_RVALID), .I_RREADY(I_RREADY),
    .I_SLEEP_EXEC(I_SLEEP_EXEC), .I_WAKE(I_WAKE), .I_CRYSTAL_SEL(I_CRYSTAL_SEL),
    .I_ADC_ENABLED(I_ADC_ENABLED), .I_COMP_INT_REF(I_COMP_INT_REF), .O_CLK_EN(O_CLK_EN),
    .O_PERIPH_CLK_EN(O_PERIPH_CLK_EN), .O_PERIPH_IO_BLOCK(O_PERIPH_IO_BLOCK),
    .O_ADC_START(O_ADC_START), .O_IRQ_RESUME(O_IRQ_RESUME),
    .O_INPUT_BUF_EN(O_INPUT_BUF_EN), .O_COMP_DISABLE(O_COMP_DISABLE),
    .O_SLEEP_CTRL(O_SLEEP_CTRL)
  );

  // ==========================================================
  // Common tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded wait: a lost response leaves the code 3 and shows as a mismatch
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    logic [1:0] r;
    k = 0;
    r = 2'h3;
    I_AWADDR <= a;
    I_AWVALID <= 1'h1;
    I_WDATA <= {24'h000000, d};
    I_WSTRB <= 4'h1;
    I_WVALID <= 1'h1;
    I_BREADY <= 1'h1;
    while (k < 50) begin
      @(posedge I_CLK_SYS);
      k++;
      if (I_AWVALID && O_AWREADY) I_AWVALID <= 1'h0;
      if (I_WVALID && O_WREADY) I_WVALID <= 1'h0;
      if (O_BVALID) begin
        r = O_BRESP;
        I_BREADY <= 1'h0;
        break;
      end
    end
    // One edge between writes, so the next call never re-raises BREADY in this step
    @(posedge I_CLK_SYS);
    chk(32'(r), 32'(er));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int k;
    logic [1:0] r;
    logic [31:0] d;
    k = 0;
    r = 2'h3;
    d = 32'h0;
    I_ARADDR <= a;
    I_ARVALID <= 1'h1;
    I_RREADY <= 1'h1;
    while (k < 50) begin
      @(posedge I_CLK_SYS);
      k++;
      if (I_ARVALID && O_ARREADY) I_ARVALID <= 1'h0;
      if (O_RVALID) begin
        r = O_RRESP;
        d = O_RDATA;
        I_RREADY <= 1'h0;
        break;
      end
    end
    chk(d, exp);
    chk(32'(r), 32'(er));
  endtask

  task automatic go_sleep(input logic [7:0] sc, input logic [5:0] eclk, input logic eadc);
    wr(SC_ADDR, sc, RESP_OKAY);
    @(posedge I_CLK_SYS);
    I_SLEEP_EXEC <= 1'h1;
    @(posedge I_CLK_SYS);
    I_SLEEP_EXEC <= 1'h0;
    @(posedge I_CLK_SYS);
    chk(32'(O_CLK_EN), 32'(eclk));
    chk(32'(O_ADC_START), 32'(eadc));
  endtask

  // Edges counted from the one that launches the source until resume is sampled
  task automatic wake_up(input logic [8:0] src, input int ecnt);
    int k;
    k = 0;
    @(posedge I_CLK_SYS);
    I_WAKE <= slpctl_wake_t'(src);
    while (k < 60 && O_IRQ_RESUME !== 1'h1) begin
      @(posedge I_CLK_SYS);
      k++;
    end
    I_WAKE <= '0;
    chk(32'(k), 32'(ecnt));
    chk(32'(O_CLK_EN.cpu), 32'h1);
  endtask

  task automatic refuse(input logic [8:0] src, input logic [5:0] eclk);
    @(posedge I_CLK_SYS);
    I_WAKE <= slpctl_wake_t'(src);
    repeat (12) @(posedge I_CLK_SYS);
    I_WAKE <= '0;
    chk(32'(O_CLK_EN), 32'(eclk));
    chk(32'(O_IRQ_RESUME), 32'h0);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    logic [3:0] v;
    chk(32'(O_CLK_EN), 32'h3f);
    rd(SC_ADDR, 32'h0, RESP_OKAY);
    wr(SC_ADDR, 8'hff, RESP_OKAY);
    rd(SC_ADDR, 32'h7b, RESP_OKAY);
    chk(32'(O_SLEEP_CTRL), 32'h7b);
    wr(SC_ADDR, 8'h00, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      v = 4'h1 << i;
      wr(PR_ADDR, {4'h0, v}, RESP_OKAY);
      chk(32'(O_PERIPH_CLK_EN), 32'({~v[0], ~v}));
      chk(32'(O_PERIPH_IO_BLOCK[3:0]), 32'(v));
    end
    wr(PR_ADDR, 8'hff, RESP_OKAY);
    rd(PR_ADDR, 32'h0f, RESP_OKAY);
    wr(PR_ADDR, 8'h00, RESP_OKAY);
    chk(32'(O_PERIPH_CLK_EN), 32'h1f);
    wr(8'h00, 8'h55, RESP_SLVERR);
    rd(8'h00, 32'h0, RESP_SLVERR);
  endtask

  task automatic t_idle_noise();
    go_sleep(8'h00, 6'h3f, 1'h0);
    I_ADC_ENABLED <= 1'h1;
    go_sleep(8'h20, 6'h0f, 1'h1);
    chk(32'(O_INPUT_BUF_EN), 32'h1);
    wake_up(9'h001, 6);
    go_sleep(8'h28, 6'h05, 1'h1);
    refuse(9'h103, 6'h05);
    wake_up(9'h080, 6);
  endtask

  task automatic t_deep();
    go_sleep(8'h30, 6'h00, 1'h0);
    chk(32'(O_INPUT_BUF_EN), 32'h0);
    chk(32'(O_COMP_DISABLE), 32'h1);
    I_COMP_INT_REF <= 1'h1;
    @(posedge I_CLK_SYS);
    chk(32'(O_COMP_DISABLE), 32'h0);
    I_COMP_INT_REF <= 1'h0;
    refuse(9'h11b, 6'h00);
    wake_up(9'h020, STARTUP + 6);
    I_CRYSTAL_SEL <= 1'h1;
    go_sleep(8'h38, 6'h01, 1'h0);
    wake_up(9'h040, 8);
    I_CRYSTAL_SEL <= 1'h0;
    go_sleep(8'h38, 6'h00, 1'h0);
    I_RESET <= 1'h1;
    @(posedge I_CLK_SYS);
    @(posedge I_CLK_SYS);
    I_RESET <= 1'h0;
    chk(32'(O_CLK_EN), 32'h3f);
    chk(32'(O_SLEEP_CTRL), 32'h0);
    chk(32'(O_IRQ_RESUME), 32'h0);
    rd(ST_ADDR, 32'h1f9, RESP_OKAY);
  endtask

  // ==========================================================
  // Clock, watchdog and main sequence
  initial begin
    I_CLK_SYS = 1'h0;
    forever #5 I_CLK_SYS = ~I_CLK_SYS;
  end

  initial begin
    #200000;
    n_errors++;
    wrap_up();
  end

  initial begin
    I_RESET = 1'h1;
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h00;
    I_AWADDR = 8'h00;
    I_ARADDR = 8'h00;
    I_WDATA = 32'h0;
    I_WSTRB = 4'h0;
    {I_SLEEP_EXEC, I_CRYSTAL_SEL, I_ADC_ENABLED, I_COMP_INT_REF} = 4'h0;
    I_WAKE = '0;
    repeat (6) @(posedge I_CLK_SYS);
    I_RESET <= 1'h0;
    @(posedge I_CLK_SYS);
    t_regs();
    t_idle_noise();
    t_deep();
    wrap_up();
  end
endmodule
